// >>> hw/sepc_core.sv
/*
 sepc_core: three-wire serial EEPROM instruction decoder, enable latch,
 self-timed erase/write engine, ready/busy status and read-out.
 assumes pins arrive asynchronously and are oversampled by sys_clk_i, whose
 rate is well above twice the serial clock rate; srst_i stands for power-up.
*/
`timescale 1ns/1ps

// Functional notes
// - instruction: start 1, two-bit opcode, address
// - 10 read, 11 erase, 01 write location
// - opcode 00: upper address bits pick special
// - power-up leaves programming disabled
// - enable persists until disable or power loss
// - erase sets addressed location to ones
// - erase starts right after address decoded
// - deselect then reselect shows ready/busy
// - status: 0 busy, 1 ready
// - write data is 8 or 16 bits
// - write starts after last data bit
// - no status if reselected after cycle
// - erase-all sets whole array to ones
// - write-all fills every location with pattern
// - disable blocks all erase and write
// - read works enabled or disabled
// - small variant ignores address MSB, still counted
module sepc_core
   import sepc_pkg::*;
#(
   parameter int ADDR_W8 = ADDR_W8_DEF,
   parameter bit SMALL_VARIANT = 1'b0,
   parameter int WP_CYCLES = WP_CYC
) (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic srst_i,
   // serial pins from the host, asynchronous
   input wire sepc_pins_t pins_i,
   // serial data out, tri-stated by an active-low enable
   output logic do_o,
   output logic do_oe_n_o
);

   localparam int AW = ADDR_W8;
   localparam int MEM_BYTES = 1 << AW;
   localparam int TW = $clog2(WP_CYCLES + 1);
   localparam int CSW = $clog2(CS_LOW_CYC + 1);

   if (AW < 4 || AW > 14) begin : g_bad_aw
      $error("ADDR_W8 out of range");
   end
   if (WP_CYCLES <= MEM_BYTES) begin : g_bad_wp
      $error("WP_CYCLES must exceed the array size");
   end

   typedef struct packed {
      sepc_pins_t sy1;
      sepc_pins_t sy2;
      logic sk_d;
      logic cs_d;
      sepc_state_t state;
      logic [4:0] cnt;
      logic [1:0] op;
      logic [AW-1:0] addr;
      logic [15:0] sh;
      logic org16;
      logic wen;
      logic stat;
      logic dbit;
      logic doe_n;
      logic [CSW-1:0] csl;
      logic [TW-1:0] tmr;
      logic walking;
      logic [AW-1:0] walk;
      logic [AW-1:0] wend;
      logic [15:0] pat;
   } sepc_reg_t;

   sepc_reg_t r_reg;
   sepc_reg_t r_next;
   logic [7:0] mem [MEM_BYTES];

   function automatic logic [AW-1:0] loc_base(input logic [AW-1:0] a, input logic w16);
      logic [AW-1:0] b;
      b = w16 ? {a[AW-2:0], 1'b0} : a;
      if (SMALL_VARIANT) begin
         b[AW-1] = 1'b0;
      end
      return b;
   endfunction

   function automatic logic [4:0] addr_len(input logic w16);
      return w16 ? 5'(AW - 1) : 5'(AW);
   endfunction

   function automatic logic [4:0] data_len(input logic w16);
      return w16 ? DATA_W16 : DATA_W8;
   endfunction

   function automatic logic [1:0] spec_code(input logic [AW-1:0] a, input logic w16);
      return w16 ? a[AW-2 -: 2] : a[AW-1 -: 2];
   endfunction

   logic cs;
   logic dibit;
   logic sk_rise;
   logic cs_rise;
   logic cs_fall;
   logic [AW-1:0] na;
   logic [15:0] nsh;
   logic [AW-1:0] rd_base;
   logic [15:0] rd_word;
   logic go;
   logic go_all;
   logic go_erase;
   logic [15:0] go_pat;
   logic dis_hit;
   logic rd_hit;
   logic mem_we;
   logic [AW-1:0] mem_wa;
   logic [7:0] mem_wd;

   assign cs = r_reg.sy2.cs;
   assign dibit = r_reg.sy2.di;
   assign sk_rise = r_reg.sy2.sk & ~r_reg.sk_d;
   assign cs_rise = cs & ~r_reg.cs_d;
   assign cs_fall = ~cs & r_reg.cs_d;
   assign na = {r_reg.addr[AW-2:0], dibit};
   assign nsh = {r_reg.sh[14:0], dibit};
   assign rd_base = loc_base(r_reg.addr, r_reg.org16);
   assign rd_word = r_reg.org16 ? {mem[rd_base | AW'(1)], mem[rd_base]} : {8'h00, mem[rd_base]};

   // walk engine: one byte per cycle while busy
   assign mem_we = (r_reg.state == ST_BUSY) && r_reg.walking;
   assign mem_wa = r_reg.walk;
   assign mem_wd = (r_reg.org16 && r_reg.walk[0]) ? r_reg.pat[15:8] : r_reg.pat[7:0];

   always_comb begin
      r_next = r_reg;
      go = 1'b0;
      go_all = 1'b0;
      go_erase = 1'b0;
      go_pat = ERASED_WORD;
      dis_hit = 1'b0;
      rd_hit = 1'b0;
      r_next.sy1 = pins_i;
      r_next.sy2 = r_reg.sy1;
      r_next.sk_d = r_reg.sy2.sk;
      r_next.cs_d = r_reg.sy2.cs;
      // select low time, saturating
      if (cs) begin
         r_next.csl = '0;
      end else if (r_reg.csl != CSW'(CS_LOW_CYC)) begin
         r_next.csl = r_reg.csl + CSW'(1);
      end
      case (r_reg.state)
         ST_IDLE: begin
            if (cs && sk_rise && dibit == START_BIT && !r_reg.stat) begin
               r_next.state = ST_OPC;
               r_next.cnt = '0;
               r_next.org16 = r_reg.sy2.organization_select;
            end
         end
         ST_OPC: begin
            if (!cs) begin
               r_next.state = ST_IDLE;
            end else if (sk_rise) begin
               r_next.op = {r_reg.op[0], dibit};
               r_next.cnt = r_reg.cnt + 5'h01;
               if (r_reg.cnt == 5'h01) begin
                  r_next.state = ST_ADDR;
                  r_next.cnt = '0;
               end
            end
         end
         ST_ADDR: begin
            if (!cs) begin
               r_next.state = ST_IDLE;
            end else if (sk_rise) begin
               r_next.addr = na;
               r_next.cnt = r_reg.cnt + 5'h01;
               // every address bit is counted, even an ignored MSB
               if (r_reg.cnt == addr_len(r_reg.org16) - 5'h01) begin
                  r_next.cnt = '0;
                  if (r_reg.op == OP_READ) begin
                     rd_hit = 1'b1;
                     r_next.state = ST_READ;
                     r_next.doe_n = 1'b0;
                     r_next.dbit = 1'b0;
                  end else if (r_reg.op == OP_WRITE) begin
                     r_next.state = ST_DATA;
                  end else if (r_reg.op == OP_ERASE) begin
                     go = 1'b1;
                     go_erase = 1'b1;
                  end else begin
                     r_next.state = ST_END;
                     case (spec_code(na, r_reg.org16))
                        SP_ENABLE: r_next.wen = 1'b1;
                        SP_DISABLE: begin
                           r_next.wen = 1'b0;
                           dis_hit = 1'b1;
                        end
                        SP_ERASE_ALL: begin
                           go = 1'b1;
                           go_all = 1'b1;
                           go_erase = 1'b1;
                        end
                        default: r_next.state = ST_DATA;
                     endcase
                  end
               end
            end
         end
         ST_DATA: begin
            if (!cs) begin
               r_next.state = ST_IDLE;
            end else if (sk_rise) begin
               r_next.sh = nsh;
               r_next.cnt = r_reg.cnt + 5'h01;
               if (r_reg.cnt == data_len(r_reg.org16) - 5'h01) begin
                  go = 1'b1;
                  go_all = (r_reg.op == OP_SPECIAL);
                  go_pat = r_reg.org16 ? nsh : {nsh[7:0], nsh[7:0]};
               end
            end
         end
         ST_READ: begin
            if (!cs) begin
               r_next.state = ST_IDLE;
            end else if (sk_rise) begin
               // data follows the dummy zero, then streams on
               r_next.dbit = rd_word[4'(data_len(r_reg.org16) - 5'h01 - r_reg.cnt)];
               r_next.cnt = r_reg.cnt + 5'h01;
               if (r_reg.cnt == data_len(r_reg.org16) - 5'h01) begin
                  r_next.cnt = '0;
                  r_next.addr = r_reg.addr + AW'(1);
               end
            end
         end
         ST_BUSY: begin
            if (r_reg.tmr != '0) begin
               r_next.tmr = r_reg.tmr - TW'(1);
            end
            if (r_reg.walking) begin
               if (r_reg.walk == r_reg.wend) begin
                  r_next.walking = 1'b0;
               end else begin
                  r_next.walk = r_reg.walk + AW'(1);
               end
            end
            if (r_reg.tmr == '0 && !r_reg.walking) begin
               r_next.state = ST_IDLE;
            end
         end
         ST_END: begin
            if (!cs) begin
               r_next.state = ST_IDLE;
            end
         end
         default: r_next.state = ST_IDLE;
      endcase
      // launch of a program cycle, gated by the enable latch
      if (go) begin
         r_next.cnt = '0;
         if (r_reg.wen) begin
            r_next.state = ST_BUSY;
            r_next.tmr = TW'(WP_CYCLES - 1);
            r_next.walking = 1'b1;
            r_next.pat = go_erase ? ERASED_WORD : go_pat;
            if (go_all) begin
               r_next.walk = '0;
               r_next.wend = AW'(MEM_BYTES - 1);
               if (SMALL_VARIANT) begin
                  r_next.wend[AW-1] = 1'b0;
               end
            end else begin
               r_next.walk = loc_base(na, r_reg.org16);
               if (r_reg.state == ST_DATA) begin
                  r_next.walk = loc_base(r_reg.addr, r_reg.org16);
               end
               r_next.wend = r_next.walk | AW'(r_reg.org16);
            end
         end else begin
            r_next.state = ST_END;
         end
      end
      // ready/busy status after a long enough deselect
      if (cs_fall) begin
         r_next.stat = 1'b0;
         r_next.doe_n = 1'b1;
      end else if (cs_rise && r_reg.csl == CSW'(CS_LOW_CYC) && r_reg.state == ST_BUSY) begin
         r_next.stat = 1'b1;
      end
      if (r_next.stat) begin
         r_next.doe_n = 1'b0;
         r_next.dbit = (r_next.state != ST_BUSY);
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         r_reg <= '0;
         r_reg.wen <= WEN_RST;
         r_reg.doe_n <= DOE_N_RST;
      end else begin
         r_reg <= r_next;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (mem_we) begin
         mem[mem_wa] <= mem_wd;
      end
   end

   assign do_o = r_reg.dbit;
   assign do_oe_n_o = r_reg.doe_n;

   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (srst_i);

   a_power_up_disabled: assert property ($past(srst_i) |-> !r_reg.wen)
      else $error("enable latch set after reset");
   a_enable_held: assert property ($past(r_reg.wen) && !$past(dis_hit) |-> r_reg.wen)
      else $error("enable latch lost without disable");
   a_disable_clears: assert property (dis_hit |=> !r_reg.wen ##1 !r_reg.wen)
      else $error("disable instruction did not clear enable");
   a_gated_start: assert property (go && !r_reg.wen |=> r_reg.state == ST_END && !mem_we)
      else $error("program cycle started while disabled");
   a_erase_ones: assert property (go && go_erase && r_reg.wen |=> r_reg.pat == ERASED_WORD && mem_we)
      else $error("erase does not write ones");
   a_start_moment: assert property (go |-> sk_rise && (r_reg.state == ST_ADDR || r_reg.state == ST_DATA))
      else $error("program start off the final bit");
   a_write_last: assert property (go && r_reg.state == ST_DATA |-> r_reg.cnt == data_len(r_reg.org16) - 5'h01)
      else $error("write started before last data bit");
   a_write_all_span: assert property (go && go_all && r_reg.wen |=> r_reg.walk == '0 && r_reg.walking)
      else $error("write-all does not cover the array");
   a_busy_status: assert property (r_reg.stat && r_reg.state == ST_BUSY |-> !do_oe_n_o && !do_o)
      else $error("status not zero while busy");
   a_late_select: assert property (cs_rise && r_reg.state != ST_BUSY && !r_reg.stat |=> !r_reg.stat)
      else $error("status shown after cycle ended");
   a_read_any: assert property (rd_hit |=> r_reg.state == ST_READ && !do_oe_n_o && !do_o)
      else $error("read did not start with dummy zero");
   a_cycle_time: assert property ($rose(r_reg.state == ST_BUSY) |-> r_reg.tmr == TW'(WP_CYCLES - 1))
      else $error("program timer not loaded");

   c_erase_run: cover property (go && go_erase && r_reg.wen);
   c_write_all: cover property (go && go_all && !go_erase && r_reg.wen);
   c_status_ready: cover property (r_reg.stat && r_reg.state == ST_BUSY ##1 r_reg.stat && do_o);
   c_read_word: cover property (rd_hit ##[1:300] r_reg.state == ST_READ && r_reg.cnt == 5'h00);

endmodule

// >>> hw/sepc_pkg.sv
/*
 sepc_pkg: constants, opcodes, states and pin bundle for the serial EEPROM
 program control block.
 assumes a 20 MHz system clock; all times are converted to cycles of it.
*/
package sepc_pkg;

   // system clock
   localparam int CLK_PERIOD_NS = 50;

   // minimum select low time before status is shown
   localparam int TCS_MIN_NS = 250;
   localparam int CS_LOW_CYC = (TCS_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // self-timed program cycle (typical figure)
   localparam int TWP_NS = 3000000;
   localparam int WP_CYC = TWP_NS / CLK_PERIOD_NS;

   // array geometry: byte address width of the larger variant
   localparam int ADDR_W8_DEF = 9;
   localparam logic [4:0] DATA_W8 = 5'h08;
   localparam logic [4:0] DATA_W16 = 5'h10;

   // instruction framing
   localparam logic START_BIT = 1'b1;
   localparam logic [1:0] OP_SPECIAL = 2'h0;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [1:0] OP_READ = 2'h2;
   localparam logic [1:0] OP_ERASE = 2'h3;
   localparam logic [1:0] SP_DISABLE = 2'h0;
   localparam logic [1:0] SP_WRITE_ALL = 2'h1;
   localparam logic [1:0] SP_ERASE_ALL = 2'h2;
   localparam logic [1:0] SP_ENABLE = 2'h3;
   localparam logic [15:0] ERASED_WORD = 16'hFFFF;

   // reset values
   localparam logic WEN_RST = 1'b0;
   localparam logic DOE_N_RST = 1'b1;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_OPC  = 3'b001,
      ST_ADDR = 3'b010,
      ST_DATA = 3'b011,
      ST_READ = 3'b100,
      ST_BUSY = 3'b101,
      ST_END  = 3'b110
   } sepc_state_t;

   typedef struct packed {
      logic cs;
      logic sk;
      logic di;
      logic organization_select;
   } sepc_pins_t;

endpackage

// >>> testbench/sepc_host.sv
/*
 sepc_host: host controller model for the three-wire serial link.
 assumes the bench calls its tasks one at a time; organization follows set_org.
*/
`timescale 1ns/1ps

module sepc_host
   import sepc_pkg::*;
(
   // clock
   input wire logic sys_clk_i,
   // pins towards the device
   output sepc_pins_t pins_o,
   // resolved serial data out and its enable
   input wire logic dq_i,
   input wire logic dq_oe_n_i
);
   bit x16 = 1'b1;
   initial pins_o = '{cs: 1'b0, sk: 1'b0, di: 1'b0, organization_select: 1'b1};

   task automatic wait_clk(input int n);
      repeat (n) @(posedge sys_clk_i);
   endtask

   // di set up one clock ahead, sk 200 ns high and 200 ns low
   task automatic put_bit(input logic b);
      @(posedge sys_clk_i);
      pins_o.di <= b;
      wait_clk(1);
      pins_o.sk <= 1'b1;
      wait_clk(4);
      pins_o.sk <= 1'b0;
      wait_clk(2);
   endtask

   task automatic send(input logic [31:0] v, input int n);
      for (int i = n - 1; i >= 0; i--) begin
         put_bit(v[i]);
      end
   endtask

   task automatic select();
      @(posedge sys_clk_i);
      pins_o.cs <= 1'b1;
      wait_clk(2);
   endtask

   // change organization while deselected
   task automatic set_org(input bit w);
      @(posedge sys_clk_i);
      pins_o.organization_select <= w;
      x16 = w;
      wait_clk(3);
   endtask

   // drop cs, park di on the opposite level, stay low 300 ns
   task automatic deselect();
      @(posedge sys_clk_i);
      pins_o.cs <= 1'b0;
      pins_o.di <= ~pins_o.di;
      wait_clk(6);
   endtask

   task automatic instr(input logic [1:0] op, input logic [7:0] a, input logic [15:0] d,
                        input bit wd);
      select();
      send({29'h0, START_BIT, op}, 3);
      // x8 address has one more leading bit, sent as zero
      if (!x16) begin
         put_bit(1'b0);
      end
      send({24'h0, a}, 8);
      if (wd) begin
         send({16'h0, d}, x16 ? 16 : 8);
      end
   endtask

   // n words read back to back, msb first, last word in the low bits
   task automatic read_seq(input logic [7:0] a, input int n, output logic [31:0] d);
      d = 32'h0;
      instr(OP_READ, a, 16'h0000, 1'b0);
      for (int i = 0; i < (x16 ? 16 : 8) * n; i++) begin
         put_bit(1'b0);
         #1 d = {d[30:0], dq_i};
      end
      deselect();
   endtask

   // reselect after the low time, then wait for ready under a bound
   task automatic status(output logic first, output logic oe_n, output int waited);
      deselect();
      select();
      wait_clk(4);
      #1 first = dq_i;
      oe_n = dq_oe_n_i;
      waited = 0;
      while (dq_oe_n_i === 1'b0 && dq_i !== 1'b1 && waited < 1000) begin
         wait_clk(1);
         #1 waited++;
      end
      deselect();
   endtask
endmodule

// >>> testbench/serial_eeprom_program_control_test.sv
/*
 serial_eeprom_program_control_test: self-checking bench for sepc_core.
 assumes a shortened program cycle of 600 clocks; mostly x16, one x8 pass.
*/
`timescale 1ns/1ps

module serial_eeprom_program_control_test;
   import sepc_pkg::*;
   localparam int WP = 600;
   logic sys_clk_i = 1'b0;
   logic srst_i = 1'b1;
   sepc_pins_t pins;
   logic do_o;
   logic do_oe_n_o;
   wire dq = do_oe_n_o ? 1'bz : do_o;
   int err_count = 0;
   int checks_done = 0;
   logic f;
   logic o;
   int w;
   logic [31:0] rd;

   sepc_core #(.ADDR_W8(9), .SMALL_VARIANT(1'b0), .WP_CYCLES(WP)) uut (
      .sys_clk_i(sys_clk_i),
      .srst_i(srst_i),
      .pins_i(pins),
      .do_o(do_o),
      .do_oe_n_o(do_oe_n_o)
   );

   sepc_host host (
      .sys_clk_i(sys_clk_i),
      .pins_o(pins),
      .dq_i(dq),
      .dq_oe_n_i(do_oe_n_o)
   );

   initial begin
      forever #25 sys_clk_i = ~sys_clk_i;
   end

   task automatic results();
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask

   task automatic poll();
      host.status(f, o, w);
      if (w >= 1000) begin
         err_count++;
         results();
      end
   endtask

   task automatic special(input logic [1:0] sp, input logic [15:0] d, input bit wd);
      host.instr(OP_SPECIAL, {sp, 6'h00}, d, wd);
   endtask

   task automatic t_power_disabled();
      host.instr(OP_WRITE, 8'h05, 16'h1234, 1'b1);
      poll();
      chk({31'h0, o}, 32'h1);
   endtask

   task automatic t_erase_all();
      special(SP_ENABLE, 16'h0000, 1'b0);
      host.deselect();
      special(SP_ERASE_ALL, 16'h0000, 1'b0);
      poll();
      chk({30'h0, o, f}, 32'h0);
      chk({31'h0, w > 0 && w <= WP}, 32'h1);
      host.read_seq(8'h00, 2, rd);
      chk(rd, 32'hFFFFFFFF);
      host.read_seq(8'hFF, 1, rd);
      chk(rd, 32'h0000FFFF);
   endtask

   task automatic t_write();
      host.instr(OP_WRITE, 8'h03, 16'hA5C3, 1'b1);
      poll();
      chk({31'h0, o}, 32'h0);
      host.instr(OP_WRITE, 8'h04, 16'h0F1E, 1'b1);
      poll();
      host.read_seq(8'h03, 2, rd);
      chk(rd, 32'hA5C30F1E);
   endtask

   task automatic t_erase();
      host.instr(OP_ERASE, 8'h03, 16'h0000, 1'b0);
      poll();
      chk({31'h0, o}, 32'h0);
      host.read_seq(8'h03, 2, rd);
      chk(rd, 32'hFFFF0F1E);
   endtask

   task automatic t_write_all();
      special(SP_WRITE_ALL, 16'h5A5A, 1'b1);
      poll();
      host.read_seq(8'h00, 1, rd);
      chk(rd, 32'h00005A5A);
      host.read_seq(8'hFE, 2, rd);
      chk(rd, 32'h5A5A5A5A);
   endtask

   // byte organization: 9 address bits, 8 data bits
   task automatic t_x8();
      host.set_org(1'b0);
      host.instr(OP_WRITE, 8'h07, 16'h003C, 1'b1);
      poll();
      chk({31'h0, o}, 32'h0);
      host.read_seq(8'h07, 2, rd);
      chk(rd, 32'h00003C5A);
      host.set_org(1'b1);
   endtask

   task automatic t_late_status();
      host.instr(OP_WRITE, 8'h00, 16'h1111, 1'b1);
      host.deselect();
      host.wait_clk(WP + 100);
      host.select();
      host.wait_clk(6);
      chk({31'h0, do_oe_n_o}, 32'h1);
      host.deselect();
      host.read_seq(8'h00, 1, rd);
      chk(rd, 32'h00001111);
   endtask

   task automatic t_disabled();
      special(SP_DISABLE, 16'h0000, 1'b0);
      host.deselect();
      host.instr(OP_WRITE, 8'h00, 16'h2222, 1'b1);
      poll();
      chk({31'h0, o}, 32'h1);
      special(SP_ERASE_ALL, 16'h0000, 1'b0);
      poll();
      chk({31'h0, o}, 32'h1);
      host.read_seq(8'h00, 1, rd);
      chk(rd, 32'h00001111);
   endtask

   initial begin
      repeat (2) @(posedge sys_clk_i);
      srst_i <= 1'b0;
      repeat (4) @(posedge sys_clk_i);
      t_power_disabled();
      t_erase_all();
      t_write();
      t_erase();
      t_write_all();
      t_late_status();
      t_x8();
      t_disabled();
      results();
   end

   // hang guard
   initial begin
      repeat (100000) @(posedge sys_clk_i);
      err_count++;
      results();
   end
endmodule
